// ---- analog_output_setpoint_block_bench.sv ----
// Purpose: self-checking bench for the analog output setpoint block
// Assumes: rates in hundredths of percent per second, 500 ms period
// Notes: increase-to-close and fault-to-value set while disabled
`timescale 1ns/1ps
`default_nettype none
module analog_output_setpoint_block_bench;
    import aosp_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, exec_tick = 1'b0, target_we = 1'b0, opt_we = 1'b0;
    logic path_broken = 1'b0, sim_enable = 1'b0, up_bad = 1'b0;
    aosp_mode_t target_mode = MODE_DISABLED;
    logic [2:0] permitted_lower = 3'b010;
    logic [15:0] local_sp = 16'h1388, op_out = 16'h0fa0, hi = 16'h0bb8, lo = 16'h0032;
    logic [15:0] rise = 16'h03e8, fall = 16'h0000, fdelay = 16'h0001, fval = 16'h1770;
    logic [15:0] saved = 16'h0064, up_value = 16'h07d0;
    logic [7:0] opt_wdata = 8'h00;
    aosp_sig_t host_in = '0, sim_pos = '0, upstream_setpoint, transducer_pos;
    aosp_sig_t output_value, measured_position, position_feedback, back_calc_output;
    logic [7:0] signal_options;
    aosp_mode_t actual_mode;
    logic [15:0] target_value, transducer_cmd, bkcal_seen;
    logic fault_state;
    int n_fail = 0, compares = 0;
    // ==========================================
    // design and far side
    aosp_core dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .exec_tick(exec_tick), .target_mode(target_mode),
        .target_we(target_we), .permitted_lower(permitted_lower), .path_broken(path_broken),
        .retained_target(MODE_AUTO), .local_setpoint(local_sp), .upstream_setpoint(upstream_setpoint),
        .host_setpoint_input(host_in), .operator_output(op_out), .transducer_pos(transducer_pos),
        .sim_enable(sim_enable), .sim_pos(sim_pos), .setpoint_upper_bound(hi), .setpoint_lower_bound(lo),
        .rise_rate_limit(rise), .fall_rate_limit(fall), .fault_delay(fdelay), .fault_value(fval),
        .saved_setpoint(saved), .signal_options_wdata(opt_wdata), .signal_options_we(opt_we),
        .signal_options(signal_options), .actual_mode(actual_mode), .target_mode_q(),
        .target_value(target_value), .output_value(output_value), .transducer_cmd(transducer_cmd),
        .measured_position(measured_position), .position_feedback(position_feedback),
        .back_calc_output(back_calc_output), .fault_state(fault_state));
    aosp_far_end far (.clk_sys(clk_sys), .sys_rst(sys_rst), .transducer_cmd(transducer_cmd),
        .back_calc_output(back_calc_output), .up_value(up_value), .up_bad(up_bad),
        .transducer_pos(transducer_pos), .upstream_setpoint(upstream_setpoint), .bkcal_seen(bkcal_seen));
    // ==========================================
    // clock, shared tasks
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // outputs are read two clocks after the last tick, once settled
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys) exec_tick <= 1'b1;
            @(posedge clk_sys) exec_tick <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_mode(input aosp_mode_t m);
        @(posedge clk_sys) begin target_mode <= m; target_we <= 1'b1; end
        @(posedge clk_sys) target_we <= 1'b0;
        tick(1);
    endtask
    task automatic write_opts(input logic [7:0] v);
        @(posedge clk_sys) begin opt_wdata <= v; opt_we <= 1'b1; end
        @(posedge clk_sys) opt_we <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_restart;
        chk(target_value, saved, "restart setpoint");
        chk(fault_state, 1'b0, "fault after restart");
        chk(actual_mode, MODE_DISABLED, "mode after reset");
        chk(output_value.out_of_service, 1'b1, "disabled status");
        write_opts(8'h18);
        chk(signal_options, 8'h18, "options in disabled");
        tick(2);
        chk(output_value.value, 16'h0000, "disabled output kept");
    endtask
    task automatic t_auto;
        set_mode(MODE_AUTO);
        tick(1);
        chk(target_value, 16'h0258, "rise step");
        chk(output_value.value, 16'h0258, "auto output");
        chk(transducer_cmd, 16'h2710 - 16'h0258, "inverted command");
        chk(bkcal_seen, 16'h0258, "back-calc setpoint");
        chk(position_feedback.value, transducer_pos.value, "feedback");
        chk(measured_position.value, transducer_pos.value, "measured");
        tick(6);
        chk(target_value, hi, "upper clamp");
        chk(back_calc_output.limited, 1'b1, "limited flag");
        write_opts(8'h00);
        chk(signal_options, 8'h18, "options refused");
        @(posedge clk_sys) local_sp <= 16'h0000;
        tick(1);
        chk(target_value, lo, "zero fall rate to lower clamp");
    endtask
    task automatic t_manual;
        set_mode(MODE_MANUAL);
        tick(1);
        chk(output_value.value, op_out, "manual output");
        @(posedge clk_sys) begin
            sim_enable <= 1'b1;
            sim_pos <= '{16'h1234, 1'b1, 1'b0, 1'b0, 1'b0};
        end
        #1;
        chk(measured_position.value, 16'h1234, "sim position");
        chk(position_feedback.bad, 1'b1, "sim feedback status");
        chk(output_value.bad, 1'b1, "output fault status");
        @(posedge clk_sys) sim_enable <= 1'b0;
        @(posedge clk_sys) local_sp <= 16'h0bb8;
        tick(1);
        chk(output_value.value, op_out, "manual ignores setpoint");
    endtask
    task automatic t_fault;
        set_mode(MODE_CASCADE);
        tick(2);
        chk(target_value, up_value, "cascade source");
        @(posedge clk_sys) up_bad <= 1'b1;
        tick(1);
        chk(actual_mode, MODE_AUTO, "shed to auto");
        chk(fault_state, 1'b0, "fault before delay");
        tick(3);
        chk(fault_state, 1'b1, "fault after delay");
        // actual mode reaches fault hold one tick after the flag
        tick(1);
        chk(output_value.value, fval, "fault value");
        chk(transducer_cmd, 16'h2710 - fval, "inverted fault");
    endtask
    // mid-run restart with the restart option set
    task automatic t_power;
        set_mode(MODE_DISABLED);
        write_opts(8'h98);
        chk(signal_options, 8'h98, "options after disable");
        @(posedge clk_sys) sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(target_value, fval, "restart from fault value");
        chk(fault_state, 1'b0, "no fault on restart");
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        t_restart();
        t_auto();
        t_manual();
        t_fault();
        t_power();
        wrap_up();
    end
    // whole run is about 120 clocks; this span is far beyond it
    initial begin
        #50us;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- aosp_core.sv ----
// Purpose: analog output setpoint block: mode select, clamp, rate limit, fault state
// Assumes: exec_tick is a one-cycle pulse per macrocycle; inputs synchronous to clk_sys
// Notes: one evaluation per tick; mode, setpoint and output value hold between ticks
// Notes on behaviour
// - cascade actual mode drops to next permitted lower mode on bad upstream input.
// - manual output comes from operator value only, not setpoint.
// - auto uses local setpoint, cascade upstream input, host chain host input.
// - manual track option follows measured position; cleared only when disabled.
// - setpoint clamped between lower and upper bounds.
// - auto rise and fall rate limits; zero disables that direction.
// - per tick step at most rate times period fraction of a second.
// - auto writes limited setpoint to output; manual uses operator output.
// - position feedback and measured position both show valve position.
// - cascade target detects fault on bad or init-fault upstream input.
// - fault state set only after fault persists for fault delay seconds.
// - fault state holds output, or goes to fault value if option set.
// - signal options writes accepted only while disabled.
// - back-calc output carries measured position if option, else working setpoint.
// - target-to-manual option forces target to manual on fault state.
// - restart loads setpoint from fault value or saved value, no fault state.
// - increase-to-close sends complement percent to transducer.
// - track option follows measured position in fault hold or path init.
// - retained-target tracking follows cascade or host input, over position tracking.
// - limited flag in back-calc status; faults in position, output, back-calc status.
// - simulation replaces measured position and feedback with operator entries.
// - disabled mode does not execute; output kept, status bad out of service.
`timescale 1ns/1ps
`default_nettype none
module aosp_core
    import aosp_pkg::*;
#(
    parameter int unsigned W = AOSP_VW,
    parameter logic [15:0] PERIOD_MS = AOSP_PERIOD_MS,
    parameter logic [15:0] TICKS_PER_S = 16'h0002 // ticks per second of fault delay
) (
    input wire logic clk_sys,                  // system clock
    input wire logic sys_rst,                  // sync reset, restart
    input wire logic exec_tick,                // execution pulse
    input wire aosp_mode_t target_mode,        // requested mode
    input wire logic target_we,                // load target_mode
    input wire logic [2:0] permitted_lower,    // permitted below cascade: bit0 man, bit1 auto
    input wire logic path_broken,              // transducer path broken
    input wire aosp_mode_t retained_target,    // retained target mode
    input wire logic [W-1:0] local_setpoint,   // operator setpoint
    input wire aosp_sig_t upstream_setpoint,   // cascade input
    input wire aosp_sig_t host_setpoint_input, // host chain input
    input wire logic [W-1:0] operator_output,  // manual output value
    input wire aosp_sig_t transducer_pos,      // valve position from transducer
    input wire logic sim_enable,               // simulation active
    input wire aosp_sig_t sim_pos,             // simulated position entry
    input wire logic [W-1:0] setpoint_upper_bound, // clamp high
    input wire logic [W-1:0] setpoint_lower_bound, // clamp low
    input wire logic [W-1:0] rise_rate_limit,  // rise rate per second
    input wire logic [W-1:0] fall_rate_limit,  // fall rate per second
    input wire logic [15:0] fault_delay,       // seconds
    input wire logic [W-1:0] fault_value,      // fault output value
    input wire logic [W-1:0] saved_setpoint,   // nonvolatile saved value
    input wire logic [7:0] signal_options_wdata, // option write data
    input wire logic signal_options_we,        // option write strobe
    output logic [7:0] signal_options,         // stored options
    output aosp_mode_t actual_mode,            // actual mode
    output aosp_mode_t target_mode_q,          // stored target
    output logic [W-1:0] target_value,         // working setpoint
    output aosp_sig_t output_value,            // block output
    output logic [W-1:0] transducer_cmd,       // value sent to transducer
    output aosp_sig_t measured_position,       // position, engineering units
    output aosp_sig_t position_feedback,       // position, output units
    output aosp_sig_t back_calc_output,        // back-calc to upstream
    output logic fault_state                   // fault state active
);
    // ==========================================================
    // state
    // ==========================================================
    aosp_mode_t tgt_reg, act_reg;
    // options live through a restart, else the restart option could never act
    logic [7:0] opts_reg = AOSP_OPTS_RESET;
    logic [W-1:0] sp_reg, out_reg, sp_next, out_next;
    logic [31:0] fcnt_reg;
    logic fs_reg, restart_reg, lim_reg;

    // ==========================================================
    // feedback path
    // ==========================================================
    // simulation replaces transducer value and status
    wire aosp_sig_t pos = sim_enable ? sim_pos : transducer_pos;
    wire logic pos_fault = pos.bad;

    // ==========================================================
    // mode and fault detection
    // ==========================================================
    wire logic up_bad = upstream_setpoint.bad;
    // fault seen on bad or init-fault input under cascade target
    wire logic fault_seen = tgt_reg == MODE_CASCADE && (up_bad || upstream_setpoint.init_fault);
    wire logic [31:0] delay_ticks = 32'(fault_delay) * 32'(TICKS_PER_S);
    wire logic fault_due = fault_seen && fcnt_reg >= delay_ticks;
    // next lower permitted mode under cascade
    wire aosp_mode_t shed_mode = permitted_lower[1] ? MODE_AUTO : MODE_MANUAL;
    aosp_mode_t act_next;
    always_comb begin
        if (tgt_reg == MODE_DISABLED)
            act_next = MODE_DISABLED;
        else if (fs_reg)
            act_next = MODE_FAULT_HOLD;
        else if (path_broken)
            act_next = MODE_PATH_INIT;
        else if (tgt_reg == MODE_CASCADE && up_bad)
            act_next = shed_mode;
        else
            act_next = tgt_reg;
    end

    // ==========================================================
    // setpoint selection, tracking and clamping
    // ==========================================================
    wire logic in_man = act_reg == MODE_MANUAL;
    wire logic in_lo = act_reg == MODE_FAULT_HOLD || act_reg == MODE_PATH_INIT;
    wire logic ret_track = opts_reg[OPT_TRACK_RET] && (in_man || act_reg == MODE_FAULT_HOLD);
    wire logic pos_track = (opts_reg[OPT_TRACK_MAN] && in_man) || (opts_reg[OPT_TRACK_LO] && in_lo);
    wire logic [W-1:0] ret_src = retained_target == MODE_HOST_CHAIN ? host_setpoint_input.value
                                                                   : upstream_setpoint.value;
    logic [W-1:0] sel_sp;
    always_comb begin
        unique case (act_reg)
            MODE_AUTO: sel_sp = local_setpoint;
            MODE_CASCADE: sel_sp = upstream_setpoint.value;
            MODE_HOST_CHAIN: sel_sp = host_setpoint_input.value;
            default: sel_sp = sp_reg;
        endcase
        if (ret_track)
            sel_sp = ret_src; // retained target wins
        else if (pos_track)
            sel_sp = pos.value;
    end
    // clamp to bounds
    wire logic over = sel_sp > setpoint_upper_bound;
    wire logic under = sel_sp < setpoint_lower_bound;
    wire logic [W-1:0] clamped = over ? setpoint_upper_bound : under ? setpoint_lower_bound : sel_sp;

    logic [W-1:0] stepped;
    aosp_rate_step #(.W(W)) u_step (
        .cur(sp_reg),
        .tgt(clamped),
        .rise_rate(rise_rate_limit),
        .fall_rate(fall_rate_limit),
        .period_ms(PERIOD_MS),
        .enable(act_reg == MODE_AUTO),
        .nxt(stepped)
    );

    // ==========================================================
    // output value
    // ==========================================================
    always_comb begin
        sp_next = stepped;
        out_next = out_reg;
        if (act_reg == MODE_MANUAL)
            out_next = operator_output;
        else if (act_reg == MODE_FAULT_HOLD)
            out_next = opts_reg[OPT_FAULT_VAL] ? fault_value : out_reg;
        else if (act_reg == MODE_PATH_INIT)
            out_next = out_reg;
        else
            out_next = stepped;
    end

    // ==========================================================
    // clocked state; one evaluation per tick, none while disabled
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tgt_reg <= MODE_DISABLED;
            act_reg <= MODE_DISABLED;
            sp_reg <= AOSP_ZERO;
            out_reg <= AOSP_ZERO;
            fcnt_reg <= '0;
            fs_reg <= 1'b0;
            lim_reg <= 1'b0;
            restart_reg <= 1'b1;
        end else begin
            // restart load, no fault state
            restart_reg <= 1'b0;
            if (restart_reg)
                sp_reg <= opts_reg[OPT_RESTART_FV] ? fault_value : saved_setpoint;
            // option writes only while disabled
            if (signal_options_we && act_reg == MODE_DISABLED)
                opts_reg <= signal_options_wdata;
            if (target_we)
                tgt_reg <= target_mode;
            else if (exec_tick && fault_due && !fs_reg && opts_reg[OPT_TGT_MAN])
                tgt_reg <= MODE_MANUAL;
            if (exec_tick && !restart_reg) begin
                act_reg <= act_next;
                if (act_reg != MODE_DISABLED) begin
                    sp_reg <= sp_next;
                    out_reg <= out_next;
                    lim_reg <= over || under;
                end
                // fault timer restarts when the fault clears
                if (!fault_seen) begin
                    fcnt_reg <= '0;
                    fs_reg <= 1'b0;
                end else if (fault_due) begin
                    fs_reg <= 1'b1;
                end else begin
                    fcnt_reg <= fcnt_reg + 32'd1;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    wire logic disabled_mode = act_reg == MODE_DISABLED;
    assign signal_options = opts_reg;
    assign actual_mode = act_reg;
    assign target_mode_q = tgt_reg;
    assign target_value = sp_reg;
    assign fault_state = fs_reg;
    // status carries feedback faults and out of service
    assign output_value = '{value: out_reg, bad: pos_fault || disabled_mode, init_fault: 1'b0,
                            limited: 1'b0, out_of_service: disabled_mode};
    // complement for increase-to-close
    assign transducer_cmd = opts_reg[OPT_INC_CLOSE] ? W'(AOSP_FULL_SCALE) - out_reg : out_reg;
    // both views of valve position
    assign measured_position = '{value: pos.value, bad: pos_fault, init_fault: 1'b0,
                                 limited: 1'b0, out_of_service: 1'b0};
    assign position_feedback = measured_position;
    // back-calc value and status, relied on by upstream
    assign back_calc_output = '{value: opts_reg[OPT_USE_MEAS] ? pos.value : sp_reg, bad: pos_fault,
                                init_fault: 1'b0, limited: lim_reg, out_of_service: disabled_mode};

    // ==========================================================
    // checks
    // ==========================================================
    a_clamp_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(exec_tick) && !disabled_mode && !restart_reg && setpoint_lower_bound <= setpoint_upper_bound
        |=> target_value <= $past(setpoint_upper_bound)) else $error("setpoint above bound");
    a_manual_output: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_tick && act_reg == MODE_MANUAL |=> output_value.value == $past(operator_output))
        else $error("manual output wrong");
    a_opts_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
        act_reg != MODE_DISABLED && !restart_reg |=> signal_options == $past(signal_options))
        else $error("options changed outside disabled");
    a_disabled_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        disabled_mode && !restart_reg |=> output_value.value == $past(output_value.value))
        else $error("output moved while disabled");
    a_fault_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_tick && act_reg == MODE_FAULT_HOLD && !opts_reg[OPT_FAULT_VAL]
        |=> output_value.value == $past(out_reg)) else $error("fault hold moved");
    a_fault_value: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_tick && act_reg == MODE_FAULT_HOLD && opts_reg[OPT_FAULT_VAL]
        |=> output_value.value == $past(fault_value)) else $error("fault value missed");
    a_no_fault_early: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !fault_seen && exec_tick |=> !fault_state) else $error("fault state without fault");
    a_inc_close: assert property (@(posedge clk_sys) disable iff (sys_rst)
        opts_reg[OPT_INC_CLOSE] |-> transducer_cmd + out_reg == AOSP_FULL_SCALE)
        else $error("complement wrong");
    a_backcalc_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !opts_reg[OPT_USE_MEAS] |-> back_calc_output.value == target_value)
        else $error("back-calc not setpoint");
    a_shed_cascade: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exec_tick && tgt_reg == MODE_CASCADE && up_bad && !fs_reg && !path_broken
        |=> actual_mode != MODE_CASCADE) else $error("no shed on bad input");
    c_auto_run: cover property (@(posedge clk_sys) exec_tick && act_reg == MODE_AUTO);
    c_fault_set: cover property (@(posedge clk_sys) $rose(fs_reg));
    c_shed: cover property (@(posedge clk_sys) tgt_reg == MODE_CASCADE && act_reg == MODE_AUTO);
endmodule
`default_nettype wire

// ---- aosp_far_end.sv ----
// Purpose: far side of the setpoint block: upstream cascade source and valve transducer
// Assumes: valve follows the command one clock later; upstream value driven by the bench
// Notes: back-calc is captured as the upstream block would and shown for comparison
`timescale 1ns/1ps
`default_nettype none
module aosp_far_end
    import aosp_pkg::*;
(
    input wire logic clk_sys,               // system clock
    input wire logic sys_rst,               // restart
    input wire logic [15:0] transducer_cmd, // command to valve
    input wire aosp_sig_t back_calc_output, // back-calc from block
    input wire logic [15:0] up_value,       // upstream setpoint value
    input wire logic up_bad,                // upstream bad status
    output var aosp_sig_t transducer_pos,   // valve position
    output var aosp_sig_t upstream_setpoint, // cascade setpoint
    output logic [15:0] bkcal_seen          // captured back-calc
);
    // ==========================================
    // upstream side
    logic [15:0] upstream_back_calc_input_reg;
    logic [15:0] pos_reg;
    // back-calc wired into our own input, else no bumpless start
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            upstream_back_calc_input_reg <= 16'h0000;
            pos_reg <= 16'h0000;
        end else begin
            upstream_back_calc_input_reg <= back_calc_output.value;
            pos_reg <= transducer_cmd;
        end
    end
    assign bkcal_seen = upstream_back_calc_input_reg;
    assign upstream_setpoint = '{value: up_value, bad: up_bad, init_fault: 1'b0, limited: 1'b0,
                                 out_of_service: 1'b0};
    // ==========================================
    // valve side: no fault, position tracks command
    assign transducer_pos = '{value: pos_reg, bad: 1'b0, init_fault: 1'b0, limited: 1'b0,
                              out_of_service: 1'b0};
endmodule
`default_nettype wire

// ---- aosp_pkg.sv ----
// Purpose: shared types and constants for the analog output setpoint block
// Assumes: values are unsigned fixed point, full scale = 100 percent
// Notes: status is reduced to a small packed struct
package aosp_pkg;
    localparam int unsigned AOSP_VW = 16;
    localparam logic [15:0] AOSP_FULL_SCALE = 16'h2710; // 100.00 percent in hundredths
    localparam int unsigned AOSP_CLK_HZ = 200000000;
    localparam int unsigned AOSP_MS_PER_S = 1000;
    localparam logic [15:0] AOSP_PERIOD_MS = 16'h01f4; // default execution period, 500 ms
    localparam logic [15:0] AOSP_ZERO = 16'h0000;
    // option bit positions
    localparam int unsigned OPT_TRACK_MAN = 0;
    localparam int unsigned OPT_TRACK_LO = 1;
    localparam int unsigned OPT_TRACK_RET = 2;
    localparam int unsigned OPT_INC_CLOSE = 3;
    localparam int unsigned OPT_FAULT_VAL = 4;
    localparam int unsigned OPT_USE_MEAS = 5;
    localparam int unsigned OPT_TGT_MAN = 6;
    localparam int unsigned OPT_RESTART_FV = 7;
    localparam logic [7:0] AOSP_OPTS_RESET = 8'h00;

    typedef enum logic [2:0] {
        MODE_DISABLED = 3'b000,
        MODE_MANUAL = 3'b001,
        MODE_AUTO = 3'b010,
        MODE_CASCADE = 3'b011,
        MODE_HOST_CHAIN = 3'b100,
        MODE_FAULT_HOLD = 3'b101,
        MODE_PATH_INIT = 3'b110
    } aosp_mode_t;

    // value with status; bad, fault request, limited and out-of-service flags
    typedef struct packed {
        logic [15:0] value;
        logic bad;
        logic init_fault;
        logic limited;
        logic out_of_service;
    } aosp_sig_t;
endpackage

// ---- aosp_rate_step.sv ----
// Purpose: one rate-limited step of the working setpoint toward its target
// Assumes: rates are hundredths of percent per second
// Notes: pure combinational step, evaluated once per tick by the caller
`timescale 1ns/1ps
`default_nettype none
module aosp_rate_step
    import aosp_pkg::*;
#(
    parameter int unsigned W = AOSP_VW
) (
    input wire logic [W-1:0] cur,        // present working setpoint
    input wire logic [W-1:0] tgt,        // clamped target
    input wire logic [W-1:0] rise_rate,  // rise limit per second, zero = none
    input wire logic [W-1:0] fall_rate,  // fall limit per second, zero = none
    input wire logic [15:0] period_ms,   // execution period
    input wire logic enable,             // rate limiting active
    output logic [W-1:0] nxt             // next working setpoint
);
    // step = rate * period / 1 s; wide product avoids overflow
    function automatic logic [W-1:0] step_of(input logic [W-1:0] rate, input logic [15:0] ms);
        logic [W+15:0] prod;
        prod = (W+16)'(rate) * (W+16)'(ms);
        return W'(prod / (W+16)'(AOSP_MS_PER_S));
    endfunction

    wire logic up = tgt > cur;
    wire logic [W-1:0] diff = up ? tgt - cur : cur - tgt;
    wire logic [W-1:0] up_step = step_of(rise_rate, period_ms);
    wire logic [W-1:0] dn_step = step_of(fall_rate, period_ms);
    wire logic up_free = !enable || rise_rate == '0 || diff <= up_step;
    wire logic dn_free = !enable || fall_rate == '0 || diff <= dn_step;
    // move by at most rate times period each tick
    assign nxt = up ? (up_free ? tgt : cur + up_step) : (dn_free ? tgt : cur - dn_step);
endmodule
`default_nettype wire
